// >>> core/ctm_pkg.sv
/*
  Shared constants and types for the transceiver mode-control block:
  clock rate, mode-change bound, synchroniser reset levels, mode states.
  Assumes a single 100 MHz core clock.
*/
package ctm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CTM_CLK_PERIOD_NS   = 10;
  localparam int CTM_T_MODE_MAX_NS   = 20000;
  // longest time, so round down
  localparam int CTM_MODE_MAX_CYC    = CTM_T_MODE_MAX_NS / CTM_CLK_PERIOD_NS;
  localparam int CTM_MODE_DELAY_DEF  = 1000;
  localparam int CTM_TXD_TO_DEF      = 100000;

  // ----------------------------------------------------------------
  // pin synchroniser layout and reset levels
  // ----------------------------------------------------------------
  localparam int       CTM_SYNC_W      = 3;
  localparam int       CTM_BIT_MODE    = 2;
  localparam int       CTM_BIT_TXD     = 1;
  localparam int       CTM_BIT_BUS     = 0;
  // receive-only, transmit recessive, bus recessive
  localparam logic [2:0] CTM_SYNC_RESET = 3'h6;
  localparam logic     CTM_RXD_RESET   = 1'h1;
  localparam int       CTM_BUF_DEPTH   = 2;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CTM_MODE_RX,
    CTM_MODE_TO_NORMAL,
    CTM_MODE_NORMAL,
    CTM_MODE_TO_RX
  } ctm_mode_t;

endpackage

// >>> core/ctm_buf.sv
/*
  Small valid/ready buffer for the receive path.
  Assumes both sides run on clock_in; depth is a power of two.
*/
`timescale 1ns/10ps
module ctm_buf #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  // filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'h1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// >>> core/ctm_mode_ctrl.sv
/*
  Mode control of a high-speed CAN transceiver: mode-select pin handling,
  transmitter gating, transmit-input time-out and the receive path to rxd.
  Assumes the pins are asynchronous to clock_in and are synchronised here;
  the bus driver and receiver comparator sit outside this logic.
*/
// Operation
// - mode pin low selects normal mode
// - mode pin high selects receive-only mode
// - mode change ignores bus and transmit levels
// - only powered device reacts; controller drives pin
// - low transmit input dominates bus after entry
// - time-out acts only in normal mode
// - timer runs in normal mode, transmit low
// - receive-only mode: transmitter off, no drive
// - transmitter disabled until normal entry completes
// - receiver active in all modes and transitions
// - receive output tracks bus in every mode
// - receive output high recessive, low dominant
// - mode pin high disables transmitter, receiver stays
// - normal mode: transmitter follows transmit input
// - mode change completes within 20 microseconds
`timescale 1ns/10ps
module ctm_mode_ctrl
  import ctm_pkg::*;
#(
  parameter int MODE_DELAY_CYC  = CTM_MODE_DELAY_DEF,
  parameter int TXD_TIMEOUT_CYC = CTM_TXD_TO_DEF
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  // pins from the protocol controller
  input  wire logic mode_select_pin_in,
  input  wire logic txd_in,
  // bus receiver comparator level, high while dominant
  input  wire logic bus_dominant_in,
  // receive output toward the controller
  output logic      rxd_out,
  output logic      rxd_valid_out,
  input  wire logic rxd_ready_in,
  // bus driver control
  output logic      tx_enable_out,
  output logic      tx_dominant_out,
  // status
  output logic      mode_normal_out,
  output logic      mode_busy_out,
  output logic      txd_timeout_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [CTM_SYNC_W-1:0] sync1_reg;
  logic [CTM_SYNC_W-1:0] sync2_reg;
  logic                  mode_s;
  logic                  txd_s;
  logic                  bus_s;

  // first stage is read only by the second
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      sync1_reg <= CTM_SYNC_RESET;
      sync2_reg <= CTM_SYNC_RESET;
    end else begin
      sync1_reg <= {mode_select_pin_in, txd_in, bus_dominant_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign mode_s = sync2_reg[CTM_BIT_MODE];
  assign txd_s  = sync2_reg[CTM_BIT_TXD];
  assign bus_s  = sync2_reg[CTM_BIT_BUS];

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  ctm_mode_t   state_reg;
  ctm_mode_t   state_next;
  logic [31:0] settle_reg;
  logic [31:0] settle_next;
  logic        settle_done;

  assign settle_done = (settle_reg >= 32'(MODE_DELAY_CYC - 1));

  // only the mode pin steers the mode; bus and txd are not looked at
  always_comb begin
    state_next  = state_reg;
    settle_next = settle_reg + 32'h1;
    unique case (state_reg)
      CTM_MODE_RX: begin
        settle_next = '0;
        if (!mode_s) begin
          state_next = CTM_MODE_TO_NORMAL;
        end
      end
      CTM_MODE_TO_NORMAL: begin
        if (mode_s) begin
          state_next  = CTM_MODE_TO_RX;
          settle_next = '0;
        end else if (settle_done) begin
          state_next  = CTM_MODE_NORMAL;
          settle_next = '0;
        end
      end
      CTM_MODE_NORMAL: begin
        settle_next = '0;
        if (mode_s) begin
          state_next = CTM_MODE_TO_RX;
        end
      end
      CTM_MODE_TO_RX: begin
        if (!mode_s) begin
          state_next  = CTM_MODE_TO_NORMAL;
          settle_next = '0;
        end else if (settle_done) begin
          state_next  = CTM_MODE_RX;
          settle_next = '0;
        end
      end
    endcase
  end

  // power-up lands in receive-only so nothing is driven before the pin is seen
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_reg  <= CTM_MODE_RX;
      settle_reg <= '0;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
    end
  end

  // ----------------------------------------------------------------
  // transmit-input time-out
  // ----------------------------------------------------------------
  logic [31:0] txd_to_cnt_reg;
  logic        txd_to_reg;
  logic        in_normal;

  assign in_normal = (state_reg == CTM_MODE_NORMAL);

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      txd_to_cnt_reg <= '0;
    end else if (in_normal && !txd_s && !txd_to_reg) begin
      txd_to_cnt_reg <= txd_to_cnt_reg + 32'h1;
    end else begin
      txd_to_cnt_reg <= '0;
    end
  end

  // a stuck-low txd would otherwise block the whole bus
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      txd_to_reg <= 1'h0;
    end else if (!in_normal || txd_s) begin
      txd_to_reg <= 1'h0;
    end else if (txd_to_cnt_reg >= 32'(TXD_TIMEOUT_CYC - 1)) begin
      txd_to_reg <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // transmitter control
  // ----------------------------------------------------------------
  logic tx_en_reg;
  logic tx_dom_reg;

  // registered from in_normal, so off through both transitions except the first cycle of CTM_MODE_TO_RX
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      tx_en_reg  <= 1'h0;
      tx_dom_reg <= 1'h0;
    end else begin
      tx_en_reg  <= in_normal;
      tx_dom_reg <= in_normal && !txd_s && !txd_to_reg;
    end
  end

  assign tx_enable_out   = tx_en_reg;
  assign tx_dominant_out = tx_dom_reg;
  assign mode_normal_out = in_normal;
  assign txd_timeout_out = txd_to_reg;
  assign mode_busy_out   = (state_reg == CTM_MODE_TO_NORMAL) ||
                           (state_reg == CTM_MODE_TO_RX);

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  logic last_pushed_reg;
  logic rx_push_valid;
  logic rx_push_ready;
  logic rx_level;
  logic buf_valid;
  logic buf_data;
  logic rxd_reg;

  // rxd is high on recessive, low on dominant
  assign rx_level = !bus_s;
  // no mode term: the receiver never stops
  assign rx_push_valid = (rx_level != last_pushed_reg);

  // a full buffer stalls the sampler; the change is retried next cycle
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      last_pushed_reg <= CTM_RXD_RESET;
    end else if (rx_push_valid && rx_push_ready) begin
      last_pushed_reg <= rx_level;
    end
  end

  ctm_buf #(
    .WIDTH (1),
    .DEPTH (CTM_BUF_DEPTH)
  ) u_rx_buf (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (rx_push_valid),
    .in_ready_out  (rx_push_ready),
    .in_data_in    (rx_level),
    .out_valid_out (buf_valid),
    .out_ready_in  (rxd_ready_in),
    .out_data_out  (buf_data)
  );

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      rxd_reg <= CTM_RXD_RESET;
    end else if (buf_valid && rxd_ready_in) begin
      rxd_reg <= buf_data;
    end
  end

  assign rxd_out       = rxd_reg;
  assign rxd_valid_out = buf_valid;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [31:0] trans_age_reg;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in || !mode_busy_out) begin
      trans_age_reg <= '0;
    end else begin
      trans_age_reg <= trans_age_reg + 32'h1;
    end
  end

  enter_normal_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (state_reg == CTM_MODE_RX && !mode_s) |=> (state_reg == CTM_MODE_TO_NORMAL))
    else $error("low mode pin did not start normal entry");

  enter_rx_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (state_reg inside {CTM_MODE_NORMAL, CTM_MODE_TO_NORMAL} && mode_s)
      |=> (state_reg == CTM_MODE_TO_RX))
    else $error("high mode pin did not start receive-only entry");

  mode_time_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    trans_age_reg < 32'(CTM_MODE_MAX_CYC))
    else $error("mode change exceeded bound");

  rx_tx_off_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (state_reg == CTM_MODE_RX) |-> (!tx_enable_out && !tx_dominant_out))
    else $error("transmitter active in receive-only mode");

  entry_tx_off_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (state_reg == CTM_MODE_TO_NORMAL) |=> !tx_dominant_out)
    else $error("transmitter drove during normal entry");

  tx_follow_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    in_normal |=> (tx_dominant_out == (!$past(txd_s) && !$past(txd_to_reg))))
    else $error("transmitter does not follow txd");

  tx_drop_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (in_normal && mode_s) |=> ##1 (!tx_enable_out && !tx_dominant_out))
    else $error("transmitter still on after mode pin high");

  timeout_mode_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    !in_normal |=> (!txd_to_reg && txd_to_cnt_reg == '0))
    else $error("time-out active outside normal mode");

  timer_run_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (in_normal && !txd_s && !txd_to_reg)
      |=> (txd_to_cnt_reg == $past(txd_to_cnt_reg) + 32'h1))
    else $error("time-out timer did not count");

  timeout_release_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (txd_to_reg && txd_s) |=> (!txd_to_reg && !tx_dominant_out))
    else $error("time-out not released by txd high");

  rxd_level_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (buf_valid && rxd_ready_in) |=> (rxd_out == $past(buf_data)))
    else $error("rxd does not show drained bus level");

  rx_always_a: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    // the consumer may stall one cycle later; then the pop is not due yet
    ($changed(bus_s) && rx_push_ready && rxd_ready_in && !buf_valid) ##1 rxd_ready_in
      |=> (rxd_out == !$past(bus_s, 2)))
    else $error("rxd did not track bus");

  normal_entry_c: cover property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (state_reg == CTM_MODE_TO_NORMAL) ##1 in_normal ##1 tx_dominant_out);

  rx_entry_c: cover property (
    @(posedge clock_in) disable iff (!rst_b_in)
    in_normal ##1 (state_reg == CTM_MODE_TO_RX));

  timeout_c: cover property (
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(txd_to_reg));

  rx_stall_c: cover property (
    @(posedge clock_in) disable iff (!rst_b_in)
    rx_push_valid && !rx_push_ready);

  reverse_c: cover property (
    @(posedge clock_in) disable iff (!rst_b_in)
    (state_reg == CTM_MODE_TO_NORMAL) ##1 (state_reg == CTM_MODE_TO_RX));

endmodule

// >>> testbench/ctm_far_side.sv
/*
  Far side of the mode-control block: the two-wire bus seen as a wired-and
  line, and the receive-output consumer of the protocol controller.
  Assumes the bench sets other-node drive and consumer stall.
*/
`timescale 1ns/10ps
module ctm_far_side (
  // bus driver control from the block
  input  wire logic tx_enable_in,
  input  wire logic tx_dominant_in,
  // other nodes and consumer behaviour, set by the bench
  input  wire logic other_dom_in,
  input  wire logic stall_in,
  // toward the block
  output logic      bus_dominant_out,
  output logic      rxd_ready_out
);
  // ----------------------------------------------------------------
  // bus and consumer
  // ----------------------------------------------------------------
  // a disabled transmitter adds nothing, so only other nodes remain
  assign bus_dominant_out = (tx_enable_in & tx_dominant_in) | other_dom_in;
  assign rxd_ready_out    = !stall_in;
endmodule

// >>> testbench/tb_top.sv
/*
  Self-checking bench for the mode-control block with shortened counts.
  Assumes the far-side model stands for the bus and the consumer.
*/
`timescale 1ns/10ps
module tb_top;
  import ctm_pkg::*;
  // ----------------------------------------------------------------
  // set-up
  // ----------------------------------------------------------------
  localparam int MD = 16;
  localparam int TO = 20;
  localparam int S_TXEN = 0, S_NORM = 1, S_BUSY = 2, S_TO = 3, S_RXD = 4, S_VAL = 5, S_DOM = 6;
  logic clock_in  = 1'h0;
  logic rst_b     = 1'h0;
  logic mode_pin  = 1'h1;
  logic txd       = 1'h1;
  logic other_dom = 1'h0;
  logic stall     = 1'h0;
  logic bus_dom, rxd_ready, rxd, rxd_valid, tx_en, tx_dom, mode_norm, mode_busy, txd_to;
  int   n_mismatch = 0;
  int   n_checks   = 0;
  always #5 clock_in = ~clock_in;
  ctm_mode_ctrl #(.MODE_DELAY_CYC(MD), .TXD_TIMEOUT_CYC(TO)) ctm_mode_ctrl_inst (
    .clock_in(clock_in), .rst_b_in(rst_b), .mode_select_pin_in(mode_pin), .txd_in(txd),
    .bus_dominant_in(bus_dom), .rxd_out(rxd), .rxd_valid_out(rxd_valid),
    .rxd_ready_in(rxd_ready), .tx_enable_out(tx_en), .tx_dominant_out(tx_dom),
    .mode_normal_out(mode_norm), .mode_busy_out(mode_busy), .txd_timeout_out(txd_to));
  ctm_far_side ctm_far_side_inst (
    .tx_enable_in(tx_en), .tx_dominant_in(tx_dom), .other_dom_in(other_dom),
    .stall_in(stall), .bus_dominant_out(bus_dom), .rxd_ready_out(rxd_ready));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      S_TXEN:  pick = tx_en;
      S_NORM:  pick = mode_norm;
      S_BUSY:  pick = mode_busy;
      S_TO:    pick = txd_to;
      S_RXD:   pick = rxd;
      S_VAL:   pick = rxd_valid;
      default: pick = tx_dom;
    endcase
  endfunction
  // outputs are looked at on the falling edge, well away from updates
  task automatic wait_val(input int sel, input logic v, input int bound, output int cyc);
    cyc = 0;
    while (pick(sel) !== v) begin
      @(negedge clock_in);
      cyc++;
      if (cyc > bound) begin
        n_mismatch++;
        $display("[FAIL] t=%0t seen=%h expected=%h", $time, pick(sel), v);
        close_out();
      end
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({tx_en, tx_dom, mode_norm, mode_busy, txd_to}, 8'h00);
    check(rxd, 8'h01);
    check(rxd_valid, 8'h00);
  endtask
  task automatic t_enter_txd_low();
    int c1;
    int c2;
    txd      = 1'h0;
    mode_pin = 1'h0;
    wait_val(S_BUSY, 1'h1, 8, c1);
    for (int i = 0; i < MD - 1; i++) begin
      check(tx_en, 8'h00);
      @(negedge clock_in);
    end
    wait_val(S_TXEN, 1'h1, CTM_MODE_MAX_CYC, c2);
    check(c1 + c2 + MD <= CTM_MODE_MAX_CYC, 8'h01);
    check(mode_norm, 8'h01);
    check(tx_dom, 8'h01);
    wait_val(S_RXD, 1'h0, 8, c1);
  endtask
  task automatic t_timeout();
    int c;
    wait_val(S_TO, 1'h1, TO + 8, c);
    @(negedge clock_in);
    repeat (4) begin
      check({txd_to, tx_dom}, 8'h02);
      @(negedge clock_in);
    end
    txd = 1'h1;
    wait_val(S_TO, 1'h0, 8, c);
    txd = 1'h0;
    wait_val(S_DOM, 1'h1, 8, c);
    txd = 1'h1;
    wait_val(S_DOM, 1'h0, 8, c);
  endtask
  task automatic t_leave();
    int c;
    txd      = 1'h0;
    mode_pin = 1'h1;
    wait_val(S_TXEN, 1'h0, 8, c);
    wait_val(S_NORM, 1'h0, 8, c);
    wait_val(S_BUSY, 1'h0, CTM_MODE_MAX_CYC, c);
    repeat (TO + 10) begin
      check({tx_en, tx_dom, txd_to}, 8'h00);
      @(negedge clock_in);
    end
    wait_val(S_RXD, 1'h1, 8, c);
    txd = 1'h1;
  endtask
  task automatic t_bus_during_change();
    int c;
    other_dom = 1'h1;
    wait_val(S_RXD, 1'h0, 8, c);
    mode_pin = 1'h0;
    wait_val(S_BUSY, 1'h1, 8, c);
    other_dom = 1'h0;
    wait_val(S_RXD, 1'h1, 8, c);
    check(mode_busy, 8'h01);
    wait_val(S_TXEN, 1'h1, CTM_MODE_MAX_CYC, c);
    other_dom = 1'h1;
    wait_val(S_RXD, 1'h0, 8, c);
    check(tx_dom, 8'h00);
    mode_pin = 1'h1;
    wait_val(S_BUSY, 1'h1, 8, c);
    other_dom = 1'h0;
    wait_val(S_RXD, 1'h1, 8, c);
    check(mode_busy, 8'h01);
    wait_val(S_BUSY, 1'h0, CTM_MODE_MAX_CYC, c);
  endtask
  task automatic t_stall();
    int c;
    stall = 1'h1;
    for (int i = 0; i < 3; i++) begin
      other_dom = ~other_dom;
      repeat (4) @(negedge clock_in);
      check({rxd_valid, rxd}, 8'h03);
    end
    stall = 1'h0;
    wait_val(S_RXD, 1'h0, 8, c);
    wait_val(S_VAL, 1'h0, 8, c);
    check(rxd, 8'h00);
    other_dom = 1'h0;
    wait_val(S_RXD, 1'h1, 8, c);
  endtask
  // pin reversed halfway through each transition restarts the other one
  task automatic t_reverse();
    int c;
    mode_pin = 1'h0;
    wait_val(S_BUSY, 1'h1, 8, c);
    repeat (MD / 2) @(negedge clock_in);
    mode_pin = 1'h1;
    for (int i = 0; i < MD + 2; i++) begin
      check({tx_en, tx_dom, mode_norm, mode_busy}, 8'h01);
      @(negedge clock_in);
    end
    wait_val(S_BUSY, 1'h0, CTM_MODE_MAX_CYC, c);
    check(mode_norm, 8'h00);
    mode_pin = 1'h0;
    wait_val(S_TXEN, 1'h1, CTM_MODE_MAX_CYC, c);
    mode_pin = 1'h1;
    wait_val(S_BUSY, 1'h1, 8, c);
    repeat (MD / 2) @(negedge clock_in);
    check(tx_en, 8'h00);
    mode_pin = 1'h0;
    wait_val(S_TXEN, 1'h1, CTM_MODE_MAX_CYC, c);
    check(mode_norm, 8'h01);
    mode_pin = 1'h1;
    wait_val(S_BUSY, 1'h1, 8, c);
    wait_val(S_BUSY, 1'h0, CTM_MODE_MAX_CYC, c);
    check({tx_en, mode_norm}, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clock_in);
    rst_b = 1'h1;
    @(negedge clock_in);
    t_reset();
    t_enter_txd_low();
    t_timeout();
    t_leave();
    t_bus_during_change();
    t_stall();
    t_reverse();
    close_out();
  end
endmodule
